// File: logic/reset_combiner_regs.svh
`ifndef RESET_COMBINER_REGS_SVH
`define RESET_COMBINER_REGS_SVH

// register map, byte addresses on the bus
`define CAUSE_REG_OFFSET 32'h0000_0000

// field positions inside reset_cause_control
`define BIT_TRAP_CONFLICT 15
`define BIT_ILLEGAL_OP 14
`define BIT_CONFIG_MISMATCH 9
`define BIT_PROGMEM_BIAS 8
`define BIT_PIN_RESET 7
`define BIT_INSTR_RESET 6
`define BIT_SOFT_WDT_EN 5
`define BIT_WDT_TIMEOUT 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWNOUT 1
`define BIT_POWER_ON 0

// power-on value and implemented bits
`define CAUSE_POR_VALUE 16'h0003
`define CAUSE_IMPL_MASK 16'hC3FF

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// power-up delay, held after power-on and brown-out
`define CLOCK_MHZ 50
`define POWERUP_TIME_US 64000
`define POWERUP_CYCLES (`POWERUP_TIME_US * `CLOCK_MHZ)

`endif

// File: logic/reset_combiner_pkg.sv
package reset_combiner_pkg;

    // reset sources arriving from other clock or analog domains
    typedef struct packed {
        logic brownout;
        logic master_clear_pin;
        logic watchdog_timeout;
        logic config_mismatch;
        logic fuse_watchdog_enable;
    } ext_src_t;

    // events from cpu logic on the system clock
    typedef struct packed {
        logic instr_reset;
        logic trap_conflict;
        logic illegal_op;
        logic uninit_pointer_reset;
        logic sleep_entry;
        logic idle_entry;
        logic asleep;
    } cpu_evt_t;

    // reset sequencer states
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_POWERUP_TIMER = 3'b010,
        ST_RUN = 3'b100
    } seq_state_t;

    // synchroniser stages
    typedef struct packed {
        ext_src_t meta;
        ext_src_t stable;
    } sync_state_t;

    // whole state of the combiner
    typedef struct packed {
        seq_state_t seq;
        logic [23:0] delay_cnt;
        logic powerup_timer_due;
        logic [15:0] cause;
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic master_reset;
        logic wdt_enable;
        logic bias_down;
    } core_state_t;

endpackage

// File: logic/source_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser for the asynchronous reset sources
module source_sync (
    input wire logic clock,
    input wire logic reset_n,
    input wire reset_combiner_pkg::ext_src_t async_in,
    output reset_combiner_pkg::ext_src_t sync_out
);
    import reset_combiner_pkg::*;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // first stage feeds only the second stage
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = async_in;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stable;

endmodule

`default_nettype wire

// File: logic/reset_source_combiner_status.sv
// Contract
// - master reset is active while any reset source is active
// - sources: power-on, pin, instruction, watchdog, brown-out, mismatch, trap, opcode, pointer
// - every reset type sets its own flag in the cause register
// - power-on clears all bits except brown-out and power-on, which become one
// - software may set or clear any flag; setting never causes a reset
// - bit 15 set by trap conflict, cleared by power-on only
// - bit 14 set by illegal opcode or uninitialised pointer, cleared by power-on only
// - bit 9 set by configuration mismatch, cleared by power-on only
// - bit 8 one keeps flash bias in sleep; zero powers down, regulator standby
// - bit 7 set by master clear pin reset, cleared by power-on only
// - bit 6 set by reset instruction, cleared by power-on only
// - bit 5 enables watchdog; fuse at one forces watchdog enabled
// - bit 4 set by watchdog timeout, cleared by power-save instruction or power-on
// - bit 3 set on sleep entry, cleared by power-on only
// - bit 2 set on idle entry, cleared by power-on only
// - bit 1 set by brown-out and power-on; only software clears it
// - bit 0 set by power-on; only software clears it
// - bits 13 to 10 are unimplemented and read zero
// - unreset registers keep contents through every reset but power-on
// - master reset released only after the power-up delay expires; the code applies the delay after power-on and brown-out only
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "reset_combiner_regs.svh"

module reset_source_combiner_status #(
    parameter int unsigned POWERUP_CYCLES = `POWERUP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire reset_combiner_pkg::ext_src_t ext_src,
    input wire reset_combiner_pkg::cpu_evt_t cpu_evt,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic master_reset,
    output logic watchdog_enable,
    output logic bias_down_standby
);
    import reset_combiner_pkg::*;

    localparam logic [23:0] DELAY_LAST = 24'(POWERUP_CYCLES - 1);

    // value every flop takes at power-on
    localparam core_state_t CORE_RESET = '{
        seq: ST_HOLD,
        delay_cnt: 24'h000000,
        powerup_timer_due: 1'b1,
        cause: `CAUSE_POR_VALUE,
        aw_held: 1'b0,
        aw_addr: 32'h00000000,
        w_held: 1'b0,
        w_data: 16'h0000,
        w_strb: 2'h0,
        awready: 1'b1,
        wready: 1'b1,
        bvalid: 1'b0,
        bresp: `RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: 32'h00000000,
        rresp: `RESP_OKAY,
        master_reset: 1'b1,
        wdt_enable: 1'b1,
        bias_down: 1'b0
    };

    ext_src_t src_s;
    core_state_t st_r;
    core_state_t st_nxt;
    logic any_src;
    logic wr_fire;
    logic wr_hit;
    logic rd_fire;
    logic power_save;

    // bring the asynchronous sources onto the system clock
    source_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(ext_src),
        .sync_out(src_s)
    );

    // any active source, the fuse input excluded
    assign any_src = src_s.brownout | src_s.master_clear_pin | src_s.watchdog_timeout
                   | src_s.config_mismatch | cpu_evt.instr_reset | cpu_evt.trap_conflict
                   | cpu_evt.illegal_op | cpu_evt.uninit_pointer_reset;

    // bus handshake terms
    assign wr_fire = st_r.aw_held & st_r.w_held & ~st_r.bvalid;
    assign wr_hit = (st_r.aw_addr[31:2] == `CAUSE_REG_OFFSET >> 2);
    assign rd_fire = s_axi_arvalid & st_r.arready;
    assign power_save = cpu_evt.sleep_entry | cpu_evt.idle_entry;

    // next state of the whole block
    always_comb begin
        st_nxt = st_r;

        // reset sequencer: hold, then power-up delay where due, then run
        case (st_r.seq)
            ST_HOLD: begin
                if (!any_src) begin
                    if (st_r.powerup_timer_due) begin
                        st_nxt.seq = ST_POWERUP_TIMER;
                        st_nxt.delay_cnt = 24'h000000;
                    end else begin
                        st_nxt.seq = ST_RUN;
                    end
                end
            end
            ST_POWERUP_TIMER: begin
                if (any_src) begin
                    st_nxt.seq = ST_HOLD;
                end else if (st_r.delay_cnt >= DELAY_LAST) begin
                    st_nxt.seq = ST_RUN;
                    st_nxt.powerup_timer_due = 1'b0;
                end else begin
                    st_nxt.delay_cnt = st_r.delay_cnt + 24'h000001;
                end
            end
            ST_RUN: begin
                if (any_src) begin
                    st_nxt.seq = ST_HOLD;
                end
            end
            default: begin
                st_nxt.seq = ST_HOLD;
            end
        endcase

        // brown-out needs the power-up delay again
        if (src_s.brownout) begin
            st_nxt.powerup_timer_due = 1'b1;
        end

        // write address and data are taken independently
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata[15:0];
            st_nxt.w_strb = s_axi_wstrb[1:0];
        end

        // software write, byte lanes honoured; a flag write never resets
        if (wr_fire) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_hit && st_r.w_strb[0]) begin
                st_nxt.cause[7:0] = st_r.w_data[7:0];
            end
            if (wr_hit && st_r.w_strb[1]) begin
                st_nxt.cause[15:8] = st_r.w_data[15:8];
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // power-save instruction clears the timeout flag
        if (power_save) begin
            st_nxt.cause[`BIT_WDT_TIMEOUT] = 1'b0;
        end

        // hardware sets come last so they win over software
        if (cpu_evt.trap_conflict) begin
            st_nxt.cause[`BIT_TRAP_CONFLICT] = 1'b1;
        end
        if (cpu_evt.illegal_op || cpu_evt.uninit_pointer_reset) begin
            st_nxt.cause[`BIT_ILLEGAL_OP] = 1'b1;
        end
        if (src_s.config_mismatch) begin
            st_nxt.cause[`BIT_CONFIG_MISMATCH] = 1'b1;
        end
        if (src_s.master_clear_pin) begin
            st_nxt.cause[`BIT_PIN_RESET] = 1'b1;
        end
        if (cpu_evt.instr_reset) begin
            st_nxt.cause[`BIT_INSTR_RESET] = 1'b1;
        end
        if (src_s.watchdog_timeout) begin
            st_nxt.cause[`BIT_WDT_TIMEOUT] = 1'b1;
        end
        if (cpu_evt.sleep_entry) begin
            st_nxt.cause[`BIT_SLEEP] = 1'b1;
        end
        if (cpu_evt.idle_entry) begin
            st_nxt.cause[`BIT_IDLE] = 1'b1;
        end
        if (src_s.brownout) begin
            st_nxt.cause[`BIT_BROWNOUT] = 1'b1;
        end
        st_nxt.cause = st_nxt.cause & `CAUSE_IMPL_MASK;

        // read channel, one word answered a cycle after the address
        if (rd_fire) begin
            st_nxt.rvalid = 1'b1;
            if (s_axi_araddr[31:2] == `CAUSE_REG_OFFSET >> 2) begin
                st_nxt.rdata = {16'h0000, st_r.cause};
                st_nxt.rresp = `RESP_OKAY;
            end else begin
                st_nxt.rdata = 32'h00000000;
                st_nxt.rresp = `RESP_SLVERR;
            end
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // ready flags registered from the next occupancy
        st_nxt.awready = ~st_nxt.aw_held;
        st_nxt.wready = ~st_nxt.w_held;
        st_nxt.arready = ~st_nxt.rvalid;

        // outputs steered by the cause register and sequencer
        st_nxt.master_reset = (st_nxt.seq != ST_RUN);
        st_nxt.wdt_enable = src_s.fuse_watchdog_enable | st_nxt.cause[`BIT_SOFT_WDT_EN];
        st_nxt.bias_down = cpu_evt.asleep & ~st_nxt.cause[`BIT_PROGMEM_BIAS];
    end

    // only power-on returns the flags to their start value
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= CORE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ports straight from the state flops
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready = st_r.wready;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign master_reset = st_r.master_reset;
    assign watchdog_enable = st_r.wdt_enable;
    assign bias_down_standby = st_r.bias_down;

endmodule

`default_nettype wire

// File: testbench/reset_combiner_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module reset_combiner_asserts (
    input wire logic clock,
    input wire logic reset_n,
    input wire reset_combiner_pkg::ext_src_t ext_src,
    input wire reset_combiner_pkg::cpu_evt_t cpu_evt,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic master_reset,
    input wire logic watchdog_enable,
    input wire logic bias_down_standby
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // any cpu-side or external reset source
    wire logic cpu_src = |cpu_evt[6:3];
    wire logic ext_any = |ext_src[4:1];
    sequence ext_held; ext_any[*4]; endsequence
    sequence hold_8; master_reset[*8]; endsequence
    AST_CPU_SOURCE: assert property (cpu_src |=> master_reset)
        else $error("cpu source without master reset");
    AST_EXT_SOURCE: assert property (ext_held |-> master_reset)
        else $error("external source without master reset");
    AST_NO_SPURIOUS: assert property ($rose(master_reset) |->
        $past(cpu_src) || $past(ext_any, 2) || $past(ext_any, 3)) else $error("reset with no source");
    AST_NO_EARLY_DROP: assert property ($fell(master_reset) |->
        !$past(cpu_src) && !$past(ext_any, 3)) else $error("reset dropped while source active");
    AST_POWERON_DELAY: assert property ($rose(reset_n) |-> hold_8)
        else $error("power-on delay too short");
    AST_BROWNOUT_DELAY: assert property ($fell(ext_src.brownout) |-> hold_8)
        else $error("brown-out delay too short");
    AST_FUSE_WDT: assert property (ext_src.fuse_watchdog_enable[*4] |-> watchdog_enable)
        else $error("fuse does not force watchdog");
    AST_BIAS_AWAKE: assert property (!$past(cpu_evt.asleep) |-> !bias_down_standby)
        else $error("bias down while awake");
    AST_READ_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 &&
        s_axi_rdata[13:10] == 4'h0) else $error("unimplemented bits read nonzero");
endmodule
bind reset_source_combiner_status reset_combiner_asserts reset_combiner_asserts_inst (
    .clock(clock), .reset_n(reset_n), .ext_src(ext_src), .cpu_evt(cpu_evt),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .master_reset(master_reset),
    .watchdog_enable(watchdog_enable), .bias_down_standby(bias_down_standby));
`default_nettype wire

// File: testbench/source_model.sv
`timescale 1ns/100ps
`default_nettype none
module source_model (
    input wire logic clock,
    input wire logic go,
    input wire logic [3:0] sel,
    input wire logic [3:0] len,
    input wire logic fuse,
    input wire logic asleep,
    output wire reset_combiner_pkg::ext_src_t ext_src,
    output wire reset_combiner_pkg::cpu_evt_t cpu_evt,
    output wire logic busy
);
    logic [9:0] lv_r = '0;
    logic [3:0] cnt_r = '0;
    // one source per request, power-save entries as single pulses
    always @(posedge clock) begin
        if (go && cnt_r == 4'h0) begin
            lv_r <= 10'h001 << sel;
            cnt_r <= (sel > 4'h7) ? 4'h1 : len;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
            if (cnt_r == 4'h1)
                lv_r <= '0;
        end
    end
    // inactive sources rest low
    assign busy = cnt_r != 4'h0;
    assign ext_src = {lv_r[0], lv_r[1], lv_r[2], lv_r[3], fuse};
    assign cpu_evt = {lv_r[4], lv_r[5], lv_r[6], lv_r[7], lv_r[8], lv_r[9], asleep};
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
    import reset_combiner_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, go = 1'b0, fuse = 1'b0, asleep = 1'b0;
    logic [3:0] sel = 4'h0, len = 4'h0;
    ext_src_t ext_src;
    cpu_evt_t cpu_evt;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic busy, awready, wready, bvalid, arready, rvalid, master_reset, watchdog_enable, bias_down_standby;
    logic [1:0] bresp, rresp;
    int err_count = 0, checks = 0, cyc = 0, exp_r = 0;
    int bit_of[10] = '{1, 7, 4, 9, 6, 15, 14, 14, 3, 2};
    source_model source_model_inst (.clock(clock), .go(go), .sel(sel), .len(len), .fuse(fuse),
        .asleep(asleep), .ext_src(ext_src), .cpu_evt(cpu_evt), .busy(busy));
    reset_source_combiner_status #(.POWERUP_CYCLES(8)) reset_source_combiner_status_inst (
        .clock(clock), .reset_n(reset_n), .ext_src(ext_src), .cpu_evt(cpu_evt),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .master_reset(master_reset), .watchdog_enable(watchdog_enable),
        .bias_down_standby(bias_down_standby));
    // clock and hang guard
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic chk_reg();
        logic [31:0] d;
        logic [1:0] r;
        rd(32'h0, d, r);
        `CHK("cause", 32'(exp_r), d)
        `CHK("rresp", 2'h0, r)
    endtask
    task automatic start(input int s, input int l);
        @(posedge clock);
        sel <= 4'(s);
        len <= 4'(l);
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask
    // wait for release, then update the model and compare
    task automatic settle(input int s);
        logic saw;
        saw = 1'b0;
        for (int i = 0; i < 80; i++) begin
            @(posedge clock);
            saw |= master_reset;
            if (i > 6 && !busy && !master_reset) break;
        end
        `CHK("reset seen", s < 8, saw)
        `CHK("released", 1'b0, master_reset)
        if (s > 7) exp_r &= ~32'h10;
        exp_r |= 1 << bit_of[s];
        chk_reg();
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int v;
        void'($urandom(32'hB283F827));
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        exp_r = 3;
        chk_reg();
        // every source, cleared by software after reading
        for (int s = 0; s < 10; s++) begin
            start(s, 4 + $urandom_range(11));
            settle(s);
            wr(32'h0, 32'h0, r);
            exp_r = 0;
        end
        // software writes, watchdog enable and sleep bias
        asleep <= 1'b1;
        repeat (4) begin
            v = $urandom;
            wr(32'h0, v, r);
            exp_r = v & 32'hC3FF;
            `CHK("bresp", 2'h0, r)
            chk_reg();
            `CHK("no reset", 1'b0, master_reset)
            `CHK("wdt", exp_r[5], watchdog_enable)
            `CHK("bias", ~exp_r[8], bias_down_standby)
        end
        fuse <= 1'b1;
        wr(32'h0, 32'h0, r);
        exp_r = 0;
        chk_reg();
        `CHK("wdt fuse", 1'b1, watchdog_enable)
        // unmapped place
        wr(32'h10, 32'hFFFF, r);
        `CHK("bresp bad", 2'h2, r)
        rd(32'h10, d, r);
        `CHK("rresp bad", 2'h2, r)
        `CHK("rdata bad", 32'h0, d)
        chk_reg();
        // write during an active source, flag kept
        start(4, 15);
        wr(32'h0, 32'h0, r);
        exp_r = 0;
        settle(4);
        // accumulate flags, sleep clears time-out, then power-on
        start(2, 5);
        settle(2);
        start(8, 1);
        settle(8);
        start(5, 6);
        settle(5);
        start(0, 9);
        settle(0);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        exp_r = 3;
        chk_reg();
        conclude();
    end
endmodule
`default_nettype wire
